// [logic/ident_resp_pkg.sv]
// shared constants and carriers for the identification responder
// assumes a byte-wide request stream already framed and error-checked upstream
package ident_resp_pkg;

	// ----------------------------------------
	// protocol codes
	// ----------------------------------------
	localparam logic [7:0] FC_ENCAP      = 8'h2b;
	localparam logic [7:0] FC_EXC_BIT    = 8'h80;
	localparam logic [7:0] IFACE_IDENT   = 8'h0e;
	localparam logic [7:0] ACC_BASIC     = 8'h01;
	localparam logic [7:0] ACC_EXTENDED  = 8'h03;
	localparam logic [7:0] ACC_SINGLE    = 8'h04;
	localparam logic [7:0] CONT_MORE     = 8'hff;
	localparam logic [7:0] CONT_DONE     = 8'h00;
	localparam logic [7:0] INDIV_FLAG    = 8'h80;
	localparam logic [7:0] EXC_FUNC      = 8'h01;
	localparam logic [7:0] EXC_ADDR      = 8'h02;
	localparam logic [7:0] EXC_VALUE     = 8'h03;

	// ----------------------------------------
	// object table: 3 basic objects of 4 bytes each
	// ----------------------------------------
	localparam int          NUM_ITEMS    = 3;
	localparam logic [7:0]  ITEM_LEN     = 8'h04;
	localparam logic [7:0]  LAST_ITEM    = 8'h02;
	localparam logic [7:0]  MAX_PER_RESP = 8'h02;
	localparam int          FIFO_DEPTH   = 16;
	localparam int          FIFO_WIDTH   = 9;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} byte_beat_type;

endpackage : ident_resp_pkg

// [logic/ident_resp.sv]
// identification response builder and byte fifo
// assumes request bytes arrive framed with a last flag and a crc/parity flag on last
//
// Notes on behaviour
// - response opens with function code 2b then interface type 0e.
// - access code byte echoes the request's value.
// - conformity level is 03, or 83 with individual access.
// - stream access: continuation ff while objects remain, else 00.
// - individual access always sends continuation 00.
// - next index holds next object when continuing, else 00.
// - object count equals objects sent; one for individual access.
// - each object is index, length, then length value bytes.
// - request with a communication error gets no response.
// - normal response echoes the request function code.
// - exception sets the function code top bit.
// - exception carries one exception code.
// - nonexistent address gives exception code 02.
// - illegal access code gives exception code 03.
// - stream access with unknown index restarts at 0.
// - individual access with unknown index gives exception 02.
`timescale 1ns/1ps

// ----------------------------------------
// fifo
// ----------------------------------------
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_b_i,
	// fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} fifo_state_type;

	logic [WIDTH-1:0] mem [DEPTH];
	fifo_state_type   st_q;
	fifo_state_type   st_d;
	logic             push;
	logic             pop;

	assign in_ready_o  = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (st_q.cnt != '0);
	assign out_data_o  = mem[st_q.rd];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.wr = st_q.wr + 1'b1;
		end
		if (pop) begin
			st_d.rd = st_q.rd + 1'b1;
		end
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[st_q.wr] <= in_data_i;
		end
	end
endmodule : byte_fifo

// ----------------------------------------
// responder
// ----------------------------------------
module ident_resp (
	// clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_b_i,
	// request byte stream
	input  wire logic                        req_valid_i,
	input  wire logic [7:0]                  req_data_i,
	input  wire logic                        req_last_i,
	input  wire logic                        req_err_i,
	// configuration
	input  wire logic                        indiv_support_i,
	// response byte stream
	output logic                             rsp_valid_o,
	output ident_resp_pkg::byte_beat_type    rsp_beat_o,
	input  wire logic                        rsp_ready_i,
	output logic                             busy_o
);
	import ident_resp_pkg::*;

	typedef enum logic [2:0] {
		S_RECV, S_HEAD, S_ITEM, S_DROP
	} phase_type;

	typedef struct packed {
		phase_type  phase;
		logic [2:0] rcnt;
		logic [7:0] fc;
		logic [7:0] acc;
		logic [7:0] idx;
		logic       bad;
		logic [3:0] hcnt;
		logic [7:0] cur;
		logic [7:0] left;
		logic [7:0] vcnt;
		logic       exc;
		logic [7:0] exc_code;
		logic       busy;
		logic       vld;
		byte_beat_type beat;
		logic          ovld;
		byte_beat_type obeat;
	} resp_state_type;

	resp_state_type st_q;
	resp_state_type st_d;
	logic           f_ready;
	logic           f_valid;
	logic [8:0]     f_data;
	logic           room;
	logic           f_take;

	// value byte for object o at position p: letters, arbitrary content
	function automatic logic [7:0] item_byte(input logic [7:0] o, input logic [7:0] p);
		item_byte = 8'h41 + {o[3:0], 4'h0} + p;
	endfunction : item_byte

	// header byte h of a normal or exception response
	logic [7:0] conf;
	logic [7:0] cnt_objs;
	logic [7:0] nxt;
	logic       more;
	logic [7:0] hdr;
	logic [3:0] hdr_len;

	always_comb begin
		conf = {indiv_support_i, 7'h00} | ACC_EXTENDED;
		more = (st_q.acc != ACC_SINGLE) && (st_q.cur + MAX_PER_RESP <= LAST_ITEM);
		nxt  = more ? st_q.cur + MAX_PER_RESP : CONT_DONE;
		if (st_q.acc == ACC_SINGLE) begin
			cnt_objs = 8'h01;
		end else if (more) begin
			cnt_objs = MAX_PER_RESP;
		end else begin
			cnt_objs = LAST_ITEM + 8'h01 - st_q.cur;
		end
		hdr_len = st_q.exc ? 4'h3 : 4'h7;
		unique case (st_q.hcnt)
			4'h0: hdr = st_q.exc ? (st_q.fc | FC_EXC_BIT) : st_q.fc;
			4'h1: hdr = IFACE_IDENT;
			4'h2: hdr = st_q.exc ? st_q.exc_code : st_q.acc;
			4'h3: hdr = conf;
			4'h4: hdr = more ? CONT_MORE : CONT_DONE;
			4'h5: hdr = nxt;
			default: hdr = cnt_objs;
		endcase
	end

	always_comb begin
		st_d       = st_q;
		st_d.vld   = 1'b0;
		st_d.beat  = '0;
		// output stage keeps the response port on a flop
		if (f_take) begin
			st_d.ovld  = f_valid;
			st_d.obeat = f_data;
		end
		unique case (st_q.phase)
			S_RECV: begin
				if (req_valid_i) begin
					st_d.rcnt = (st_q.rcnt == 3'h7) ? st_q.rcnt : st_q.rcnt + 3'h1;
					unique case (st_q.rcnt)
						3'h0: st_d.fc = req_data_i;
						3'h1: st_d.bad = (req_data_i != IFACE_IDENT);
						3'h2: st_d.acc = req_data_i;
						3'h3: st_d.idx = req_data_i;
						default: st_d.bad = 1'b1;
					endcase
					if (req_last_i) begin
						// a short request would reuse fields of the one before
						if (st_q.rcnt != 3'h3) begin
							st_d.bad = 1'b1;
						end
						st_d.rcnt = '0;
						st_d.hcnt = '0;
						st_d.exc  = 1'b0;
						st_d.cur  = st_d.idx;
						if (req_err_i) begin
							st_d.phase = S_RECV;
						end else begin
							st_d.phase = S_HEAD;
							st_d.busy  = 1'b1;
							if (st_d.fc != FC_ENCAP || st_d.bad) begin
								st_d.exc = 1'b1;
								st_d.exc_code = EXC_FUNC;
							end else if (st_d.acc < ACC_BASIC || st_d.acc > ACC_SINGLE
									|| (st_d.acc == ACC_SINGLE && !indiv_support_i)) begin
								st_d.exc = 1'b1;
								st_d.exc_code = EXC_VALUE;
							end else if (st_d.idx > LAST_ITEM) begin
								if (st_d.acc == ACC_SINGLE) begin
									st_d.exc = 1'b1;
									st_d.exc_code = EXC_ADDR;
								end else begin
									st_d.cur = 8'h00;
								end
							end
						end
					end
				end
			end
			S_HEAD: begin
				if (room) begin
					st_d.vld       = 1'b1;
					st_d.beat.data = hdr;
					st_d.hcnt      = st_q.hcnt + 4'h1;
					if (st_q.hcnt == hdr_len - 4'h1) begin
						st_d.beat.last = st_q.exc;
						st_d.phase = st_q.exc ? S_DROP : S_ITEM;
						st_d.left  = cnt_objs;
						st_d.vcnt  = '0;
					end
				end
			end
			S_ITEM: begin
				if (room) begin
					st_d.vld  = 1'b1;
					st_d.vcnt = st_q.vcnt + 8'h01;
					if (st_q.vcnt == 8'h00) begin
						st_d.beat.data = st_q.cur;
					end else if (st_q.vcnt == 8'h01) begin
						st_d.beat.data = ITEM_LEN;
					end else begin
						st_d.beat.data = item_byte(st_q.cur, st_q.vcnt - 8'h02);
					end
					if (st_q.vcnt == ITEM_LEN + 8'h01) begin
						st_d.vcnt = '0;
						st_d.cur  = st_q.cur + 8'h01;
						st_d.left = st_q.left - 8'h01;
						if (st_q.left == 8'h01) begin
							st_d.beat.last = 1'b1;
							st_d.phase = S_DROP;
						end
					end
				end
			end
			default: begin
				st_d.busy  = 1'b0;
				st_d.phase = S_RECV;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '{phase: S_RECV, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// output buffer; back-pressure stalls the builder
	// ----------------------------------------
	byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (st_q.vld),
		.in_data_i   (st_q.beat),
		.in_ready_o  (f_ready),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (f_take)
	);

	// a beat is in flight one cycle after ready is seen; waiting for it halves the build rate
	// but keeps a full fifo from refusing that beat
	assign room        = f_ready && !st_q.vld;
	assign f_take      = !st_q.ovld || rsp_ready_i;
	assign rsp_valid_o = st_q.ovld;
	assign rsp_beat_o  = st_q.obeat;
	assign busy_o      = st_q.busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_err_silent;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_RECV && req_valid_i && req_last_i && req_err_i) |=> (st_q.phase == S_RECV);
	endproperty
	a_err_silent: assert property (p_err_silent) else $error("response started after bad request");

	property p_first_byte;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_HEAD && st_q.hcnt == 4'h0 && room)
			|=> st_q.vld && st_q.beat.data == (st_q.exc ? ($past(st_q.fc) | FC_EXC_BIT) : $past(st_q.fc));
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("function code byte wrong");

	property p_single_done;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_HEAD && st_q.hcnt == 4'h4 && !st_q.exc && st_q.acc == ACC_SINGLE && room)
			|=> st_q.beat.data == CONT_DONE;
	endproperty
	a_single_done: assert property (p_single_done) else $error("individual access continuation not zero");

	property p_next_zero;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_HEAD && st_q.hcnt == 4'h5 && !st_q.exc && !more && room)
			|=> st_q.beat.data == 8'h00;
	endproperty
	a_next_zero: assert property (p_next_zero) else $error("next index not zero when done");

	property p_bad_access;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_RECV && req_valid_i && req_last_i && !req_err_i && st_q.rcnt == 3'h3
			&& st_q.fc == FC_ENCAP && !st_q.bad && (st_q.acc == 8'h00 || st_q.acc > ACC_SINGLE))
			|=> st_q.exc && st_q.exc_code == EXC_VALUE;
	endproperty
	a_bad_access: assert property (p_bad_access) else $error("illegal access code not refused");

	property p_exc_single;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_q.phase == S_HEAD && st_q.exc && st_q.hcnt == 4'h2 && room)
			|=> st_q.vld && st_q.beat.data == st_q.exc_code && st_q.beat.last;
	endproperty
	a_exc_single: assert property (p_exc_single) else $error("exception frame not closed after its code");
endmodule : ident_resp

// [dv/ident_client.sv]
// client model: sends one request at a time, collects response bytes
// assumes the bench reads rsp_q and last_at by hierarchical reference
`timescale 1ns/1ps
module ident_client (
	// clock and reset
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_b_i,
	// request side
	output logic                               req_valid_o,
	output logic [7:0]                         req_data_o,
	output logic                               req_last_o,
	output logic                               req_err_o,
	// response side
	input  wire logic                          rsp_valid_i,
	input  wire ident_resp_pkg::byte_beat_type rsp_beat_i,
	output logic                               rsp_ready_o,
	input  wire logic                          busy_i
);
	import ident_resp_pkg::*;
	logic [7:0] rsp_q[$];
	int         last_at = -1;
	int         hold_cnt = 0;
	logic       exc_seen = 1'b0;
	initial begin
		req_valid_o = 1'b0;
		req_data_o  = 8'h00;
		req_last_o  = 1'b0;
		req_err_o   = 1'b0;
		rsp_ready_o = 1'b1;
	end
	// stalls the drain side while hold_cnt runs down
	always @(posedge core_clk_i) begin
		if (rsp_valid_i && rsp_ready_o) begin
			if (rsp_beat_i.last)
				last_at <= rsp_q.size();
			// top bit of the first byte flags an exception frame
			if (rsp_q.size() == 0)
				exc_seen <= rsp_beat_i.data[7];
			rsp_q.push_back(rsp_beat_i.data);
		end
		rsp_ready_o <= (hold_cnt == 0);
		if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
	end
	task automatic send(input logic [7:0] b[$], input logic err, input int stall);
		int w;
		w = 0;
		while (busy_i !== 1'b0 && w < 500) begin
			@(posedge core_clk_i);
			w++;
		end
		rsp_q.delete();
		last_at = -1;
		hold_cnt = stall;
		foreach (b[i]) begin
			@(posedge core_clk_i);
			req_valid_o <= 1'b1;
			req_data_o  <= b[i];
			req_last_o  <= (i == b.size() - 1);
			req_err_o   <= err && (i == b.size() - 1);
		end
		@(posedge core_clk_i);
		req_valid_o <= 1'b0;
		req_last_o  <= 1'b0;
		req_err_o   <= 1'b0;
		// released line shows the inverse, not a stale byte
		req_data_o  <= ~b[b.size() - 1];
	endtask : send
endmodule : ident_client

// [dv/ident_resp_tb.sv]
// self-checking bench for the identification responder
// assumes the client model drives requests and drains responses
`timescale 1ns/1ps
module ident_resp_tb;
	import ident_resp_pkg::*;
	logic          core_clk_i;
	logic          rst_b_i;
	logic          indiv_support_i;
	logic          req_valid;
	logic [7:0]    req_data;
	logic          req_last;
	logic          req_err;
	logic          rsp_valid;
	byte_beat_type rsp_beat;
	logic          rsp_ready;
	logic          busy;
	int            mismatches = 0;
	int            n_checks = 0;

	ident_resp i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid),
		.req_data_i(req_data), .req_last_i(req_last), .req_err_i(req_err),
		.indiv_support_i(indiv_support_i), .rsp_valid_o(rsp_valid), .rsp_beat_o(rsp_beat),
		.rsp_ready_i(rsp_ready), .busy_o(busy));
	ident_client i_cli (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_o(req_valid),
		.req_data_o(req_data), .req_last_o(req_last), .req_err_o(req_err), .rsp_valid_i(rsp_valid),
		.rsp_beat_i(rsp_beat), .rsp_ready_o(rsp_ready), .busy_i(busy));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask : chk

	function automatic void expect_frame(input logic [7:0] acc, input logic [7:0] idx, input logic ind,
		output logic [7:0] e[$]);
		int  s;
		int  n;
		bit  more;
		if (acc == 8'h00 || acc > ACC_SINGLE || (acc == ACC_SINGLE && !ind)) begin
			e = '{FC_ENCAP | FC_EXC_BIT, IFACE_IDENT, EXC_VALUE};
			return;
		end
		if (acc == ACC_SINGLE && idx > LAST_ITEM) begin
			e = '{FC_ENCAP | FC_EXC_BIT, IFACE_IDENT, EXC_ADDR};
			return;
		end
		s = (idx > LAST_ITEM) ? 0 : int'(idx);
		n = (acc == ACC_SINGLE) ? 1 : ((NUM_ITEMS - s < 2) ? NUM_ITEMS - s : 2);
		more = (acc != ACC_SINGLE) && (s + n < NUM_ITEMS);
		e = '{FC_ENCAP, IFACE_IDENT, acc, ind ? (INDIV_FLAG | ACC_EXTENDED) : ACC_EXTENDED,
			more ? CONT_MORE : CONT_DONE, more ? 8'(s + n) : 8'h00, 8'(n)};
		for (int k = s; k < s + n; k++) begin
			e.push_back(8'(k));
			e.push_back(ITEM_LEN);
			for (int p = 0; p < int'(ITEM_LEN); p++)
				e.push_back(8'(8'h41 + k * 16 + p));
		end
	endfunction : expect_frame

	// one request, then the whole frame, byte by byte
	task automatic run_case(input logic [7:0] fc, input logic [7:0] acc, input logic [7:0] idx,
		input int stall);
		logic [7:0] e[$];
		int         w;
		expect_frame(acc, idx, indiv_support_i, e);
		if (fc != FC_ENCAP)
			e = '{fc | FC_EXC_BIT, IFACE_IDENT, EXC_FUNC};
		i_cli.send('{fc, IFACE_IDENT, acc, idx}, 1'b0, stall);
		w = 0;
		while (i_cli.last_at < 0 && w < 400) begin
			@(posedge core_clk_i);
			w++;
		end
		chk(8'(i_cli.last_at + 1), 8'(e.size()));
		chk({7'h00, i_cli.exc_seen}, {7'h00, e.size() == 3});
		foreach (e[i])
			if (i < i_cli.rsp_q.size())
				chk(i_cli.rsp_q[i], e[i]);
	endtask : run_case

	task automatic set_indiv(input logic v);
		@(posedge core_clk_i);
		indiv_support_i <= v;
		// let the level settle before the expectation reads it
		@(posedge core_clk_i);
	endtask : set_indiv

	task automatic t_stream_follow();
		set_indiv(1'b1);
		run_case(FC_ENCAP, ACC_BASIC, 8'h00, 80);
		run_case(FC_ENCAP, ACC_BASIC, i_cli.rsp_q[5], 0);
	endtask : t_stream_follow

	task automatic t_levels();
		set_indiv(1'b0);
		for (int a = 1; a <= 3; a++)
			run_case(FC_ENCAP, 8'(a), 8'h01, 0);
	endtask : t_levels

	task automatic t_single();
		set_indiv(1'b1);
		for (int i = 0; i <= 3; i++)
			run_case(FC_ENCAP, ACC_SINGLE, 8'(i), 0);
	endtask : t_single

	task automatic t_bad();
		run_case(FC_ENCAP, 8'h05, 8'h00, 0);
		run_case(FC_ENCAP, 8'h00, 8'h00, 0);
		run_case(8'h03, ACC_BASIC, 8'h00, 0);
		set_indiv(1'b0);
		run_case(FC_ENCAP, ACC_SINGLE, 8'h00, 0);
	endtask : t_bad

	task automatic t_restart();
		run_case(FC_ENCAP, ACC_EXTENDED, 8'h7f, 0);
	endtask : t_restart

	task automatic t_comm_err();
		i_cli.send('{FC_ENCAP, IFACE_IDENT, ACC_BASIC, 8'h00}, 1'b1, 0);
		repeat (60) @(posedge core_clk_i);
		chk(8'(i_cli.rsp_q.size()), 8'h00);
		run_case(FC_ENCAP, ACC_BASIC, 8'h02, 0);
	endtask : t_comm_err

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	initial begin
		#50000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		rst_b_i = 1'b0;
		indiv_support_i = 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		t_stream_follow();
		t_levels();
		t_single();
		t_bad();
		t_restart();
		t_comm_err();
		tally_and_finish();
	end
endmodule : ident_resp_tb
